// ### include/adc_ctrl_regs.svh
// Function
// R01 - Over-range flag rises 12 clocks after overload.
// R02 - Trip level is 1.0 V times threshold/16.
// R03 - Threshold field resets to fifteen.
// R04 - One threshold serves both channels.
// R05 - Channel A: 0 runs correction, 1 clears.
// R06 - Channel B: 0 runs correction, 1 clears.
// R07 - Host keeps tuning bits written as one.
// R08 - Wide sync field decodes off/once/pins/unsupported.
// R09 - Narrow sync field uses same coding.
// R10 - Reference field selects five levels or external.
// R11 - Temperature register is read only.
// R12 - Key write restores every register default.
// R13 - Reset register clears itself afterwards.
// R14 - Sleep field selects one of four states.
// R15 - Sleep applies only while enable pin low.
// R16 - Wake-up waits the time for each state.
// R17 - Reads shift sixteen bits, MSB first.
// R18 - Host writes zero to fixed bits.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define ADDR_OVR_THR 7'h02
`define ADDR_CORR_A 7'h03
`define ADDR_SYNC_WIDE 7'h0E
`define ADDR_SYNC_REF 7'h0F
`define ADDR_CORR_B 7'h1A
`define ADDR_TEMP 7'h2B
`define ADDR_SOFT_RESET 7'h2C
`define ADDR_SLEEP 7'h37
`define RST_OVR_THR 16'h0780
`define RST_CORR 16'h4B18
`define RST_SYNC_WIDE 16'hAAA8
`define RST_SYNC_REF 16'hA000
`define RST_SLEEP 16'h0000
`define MASK_OVR_THR 16'h0780
`define MASK_SYNC_WIDE 16'hFFFC
`define MASK_SYNC_REF 16'hF070
`define MASK_SLEEP 16'hFC00
`define OVR_THR_READ_SET 16'h4000
`define THR_MSB 10
`define THR_LSB 7
`define CORR_BIT 14
`define SYNCW_MSB 15
`define SYNCW_LSB 2
`define SYNCN_MSB 15
`define SYNCN_LSB 12
`define VREF_MSB 6
`define VREF_LSB 4
`define SLEEP_MSB 15
`define SLEEP_LSB 10
`define SOFT_RESET_KEY 16'hD2F0
`define SOFT_RESET_IDLE 16'h0000
`define PIN_IDLE_LEVELS 4'hA
`define CMD_BITS 5'h08
`define FRAME_BITS 5'h18
`define OVR_DELAY_CYC 12
`define CLK_PERIOD_NS 10
`define WAKE_SHUTDOWN_NS 2500000
`define WAKE_STANDBY_NS 100000
`define WAKE_DEEP_NS 20000
`define WAKE_LIGHT_NS 2000
`define SLEEP_CODE_STANDBY 6'h20
`define SLEEP_CODE_DEEP 6'h30
`define SLEEP_CODE_LIGHT 6'h35
`endif

// ### include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef enum logic [1:0] {SYNC_OFF = 2'b00, SYNC_ONCE = 2'b01, SYNC_PINS = 2'b10, SYNC_BAD = 2'b11} sync_mode_t;
  typedef enum logic [2:0] {REF_1V0 = 3'b000, REF_1V25 = 3'b001, REF_0V9 = 3'b010, REF_0V8 = 3'b011,
                            REF_1V15 = 3'b100, REF_EXT = 3'b111} ref_sel_t;
  typedef enum logic [1:0] {SLP_SHUTDOWN = 2'b00, SLP_STANDBY = 2'b01, SLP_DEEP = 2'b10,
                            SLP_LIGHT = 2'b11} sleep_mode_t;
  typedef enum logic [1:0] {SPI_IDLE = 2'b00, SPI_CMD = 2'b01, SPI_DATA = 2'b10} spi_state_t;
  typedef enum logic [1:0] {PWR_AWAKE = 2'b00, PWR_ASLEEP = 2'b01, PWR_WAKING = 2'b10} pwr_state_t;
  // Decoded settings that steer the converter core.
  typedef struct packed {
    logic corr_run_a;
    logic corr_run_b;
    sync_mode_t sync_wide;
    sync_mode_t sync_narrow;
    ref_sel_t ref_sel;
    sleep_mode_t sleep_sel;
  } ctrl_out_t;
endpackage : adc_ctrl_pkg

// ### design/adc_control_register_bank.sv
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"
module adc_control_register_bank
  import adc_ctrl_pkg::*;
#(
  parameter int OVR_DELAY = `OVR_DELAY_CYC,
  parameter int WAKE_SHUTDOWN_CYC = `WAKE_SHUTDOWN_NS / `CLK_PERIOD_NS,
  parameter int WAKE_STANDBY_CYC = `WAKE_STANDBY_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Serial control port pins.
  input wire logic serial_clk_pin,
  input wire logic serial_enable_n_pin,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe,
  // Power enable pin.
  input wire logic power_enable_pin,
  // Converter core levels, same clock.
  input wire logic [11:0] chan_a_level,
  input wire logic [11:0] chan_b_level,
  input wire logic [8:0] temp_value,
  // Status and control towards the core.
  output logic overrange_flag_a,
  output logic overrange_flag_b,
  output ctrl_out_t ctrl,
  output logic sleep_active,
  output logic data_ready
);

  localparam int WAKE_DEEP_CYC = `WAKE_DEEP_NS / `CLK_PERIOD_NS;
  localparam int WAKE_LIGHT_CYC = `WAKE_LIGHT_NS / `CLK_PERIOD_NS;

  // Level at or above threshold/16 of full scale trips the detector.
  function automatic logic over_level(input logic [11:0] lvl, input logic [3:0] thr);
    over_level = lvl[11:8] >= thr;
  endfunction : over_level

  // Sync field decode; unknown codes count as unsupported.
  function automatic sync_mode_t decode_sync(input logic [13:0] f);
    if (f == 14'h0000) begin
      decode_sync = SYNC_OFF;
    end else if (f == 14'h1555) begin
      decode_sync = SYNC_ONCE;
    end else if (f == 14'h2AAA) begin
      decode_sync = SYNC_PINS;
    end else begin
      decode_sync = SYNC_BAD;
    end
  endfunction : decode_sync

  // Register write decode.
  function automatic logic wr_hit(input logic go, input logic [6:0] a, input logic [6:0] target);
    wr_hit = go && (a == target);
  endfunction : wr_hit

  // Pin synchronisers.
  logic [3:0] pin_sync1_reg;
  logic [3:0] pin_sync2_reg;
  logic sclk_d_reg;
  wire sclk_s = pin_sync2_reg[0];
  wire cs_n_s = pin_sync2_reg[1];
  wire sdi_s = pin_sync2_reg[2];
  wire en_s = pin_sync2_reg[3];
  wire sclk_rise = sclk_s && !sclk_d_reg;
  wire sclk_fall = !sclk_s && sclk_d_reg;

  // Two flip-flops on every pin before any logic reads it.
  // Reset loads the idle pin levels (enable high, select high, clock low), so that
  // no false clock edge or sleep entry follows the release of reset.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_sync1_reg <= `PIN_IDLE_LEVELS;
      pin_sync2_reg <= `PIN_IDLE_LEVELS;
      sclk_d_reg <= 1'b0;
    end else begin
      pin_sync1_reg <= {power_enable_pin, serial_data_in_pin, serial_enable_n_pin, serial_clk_pin};
      pin_sync2_reg <= pin_sync1_reg;
      sclk_d_reg <= sclk_s;
    end
  end

  // Serial frame: read flag, 7-bit address, 16 data bits, MSB first.
  spi_state_t spi_state_reg;
  spi_state_t spi_state_next;
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_in_reg;
  logic [6:0] addr_reg;
  logic is_read_reg;
  logic [15:0] out_shift_reg;
  logic [15:0] read_word;
  wire [6:0] rd_addr = {shift_in_reg[5:0], sdi_s};
  wire [15:0] wdata = {shift_in_reg[14:0], sdi_s};
  wire cmd_done = (spi_state_reg == SPI_CMD) && sclk_rise && (bit_cnt_reg == `CMD_BITS - 5'h01);
  wire frame_done = (spi_state_reg == SPI_DATA) && sclk_rise && (bit_cnt_reg == `FRAME_BITS - 5'h01);
  wire wr_go = frame_done && !is_read_reg;

  // Next state of the serial frame.
  always_comb begin
    spi_state_next = spi_state_reg;
    case (spi_state_reg)
      SPI_IDLE: spi_state_next = SPI_CMD;
      SPI_CMD: if (cmd_done) spi_state_next = SPI_DATA;
      SPI_DATA: if (frame_done) spi_state_next = SPI_IDLE;
      default: spi_state_next = SPI_IDLE;
    endcase
  end

  // Deselect aborts any frame; a completed frame waits for deselect.
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n_s) begin
      spi_state_reg <= SPI_IDLE;
      bit_cnt_reg <= 5'h00;
    end else if (spi_state_reg == SPI_IDLE || sclk_rise) begin
      spi_state_reg <= (spi_state_reg == SPI_DATA && frame_done) ? SPI_DATA : spi_state_next;
      bit_cnt_reg <= (spi_state_reg == SPI_IDLE) ? 5'h00 : bit_cnt_reg + 5'h01;
    end
  end

  // Input shifter and latched command.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_in_reg <= 16'h0000;
      addr_reg <= 7'h00;
      is_read_reg <= 1'b0;
    end else if (sclk_rise && !cs_n_s) begin
      shift_in_reg <= wdata;
      if (cmd_done) begin
        addr_reg <= rd_addr;
        is_read_reg <= shift_in_reg[6];
      end
    end
  end

  // Read data leaves on falling edges so the host samples on rising ones.
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n_s) begin
      out_shift_reg <= 16'h0000;
      serial_data_out_pin <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else if (cmd_done) begin
      out_shift_reg <= read_word;
      serial_data_out_oe <= shift_in_reg[6];
    end else if (sclk_fall && spi_state_reg == SPI_DATA && is_read_reg) begin
      serial_data_out_pin <= out_shift_reg[15]; // R17
      out_shift_reg <= {out_shift_reg[14:0], 1'b0}; // R17
    end
  end

  // Stored registers.
  logic [15:0] ovr_thr_reg, corr_a_reg, sync_wide_reg, sync_ref_reg, corr_b_reg, sleep_reg;
  logic [15:0] soft_key_reg;
  wire soft_go = soft_key_reg == `SOFT_RESET_KEY; // R12
  wire [15:0] ovr_thr_next = wr_hit(wr_go, addr_reg, `ADDR_OVR_THR) ? (wdata & `MASK_OVR_THR) : ovr_thr_reg;
  wire [15:0] corr_a_next = wr_hit(wr_go, addr_reg, `ADDR_CORR_A) ? wdata : corr_a_reg;
  wire [15:0] sync_wide_next = wr_hit(wr_go, addr_reg, `ADDR_SYNC_WIDE) ? (wdata & `MASK_SYNC_WIDE) : sync_wide_reg;
  wire [15:0] sync_ref_next = wr_hit(wr_go, addr_reg, `ADDR_SYNC_REF) ? (wdata & `MASK_SYNC_REF) : sync_ref_reg;
  wire [15:0] corr_b_next = wr_hit(wr_go, addr_reg, `ADDR_CORR_B) ? wdata : corr_b_reg;
  wire [15:0] sleep_next = wr_hit(wr_go, addr_reg, `ADDR_SLEEP) ? (wdata & `MASK_SLEEP) : sleep_reg;
  wire key_ok = wr_hit(wr_go, addr_reg, `ADDR_SOFT_RESET) && (wdata == `SOFT_RESET_KEY);
  wire [15:0] soft_key_next = key_ok ? `SOFT_RESET_KEY : `SOFT_RESET_IDLE; // R13
  wire [3:0] thr = ovr_thr_reg[`THR_MSB:`THR_LSB];

  // Hard reset and the keyed software reset both restore defaults.
  always_ff @(posedge sys_clk) begin
    if (rst || soft_go) begin
      ovr_thr_reg <= `RST_OVR_THR; // R03 R12
      corr_a_reg <= `RST_CORR;
      sync_wide_reg <= `RST_SYNC_WIDE;
      sync_ref_reg <= `RST_SYNC_REF;
      corr_b_reg <= `RST_CORR;
      sleep_reg <= `RST_SLEEP;
    end else begin
      ovr_thr_reg <= ovr_thr_next;
      corr_a_reg <= corr_a_next;
      sync_wide_reg <= sync_wide_next;
      sync_ref_reg <= sync_ref_next;
      corr_b_reg <= corr_b_next;
      sleep_reg <= sleep_next;
    end
  end

  // The key register holds the key for one cycle, then returns to zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      soft_key_reg <= `SOFT_RESET_IDLE;
    end else begin
      soft_key_reg <= soft_key_next; // R13
    end
  end

  // Read selection; unmapped addresses read zero.
  always_comb begin
    case (rd_addr)
      `ADDR_OVR_THR: read_word = ovr_thr_reg | `OVR_THR_READ_SET;
      `ADDR_CORR_A: read_word = corr_a_reg;
      `ADDR_SYNC_WIDE: read_word = sync_wide_reg;
      `ADDR_SYNC_REF: read_word = sync_ref_reg;
      `ADDR_CORR_B: read_word = corr_b_reg;
      `ADDR_TEMP: read_word = {7'h00, temp_value}; // R11
      `ADDR_SOFT_RESET: read_word = soft_key_reg;
      `ADDR_SLEEP: read_word = sleep_reg;
      default: read_word = 16'h0000;
    endcase
  end

  // Decoded control fields.
  wire [3:0] syncn = sync_ref_reg[`SYNCN_MSB:`SYNCN_LSB];
  wire [2:0] vref = sync_ref_reg[`VREF_MSB:`VREF_LSB];
  wire [5:0] slp = sleep_reg[`SLEEP_MSB:`SLEEP_LSB];
  wire ref_known = vref <= 3'h4;
  wire ref_sel_t ref_dec = ref_known ? ref_sel_t'(vref) : REF_EXT; // R10
  wire sleep_mode_t slp_dec = (slp == `SLEEP_CODE_LIGHT) ? SLP_LIGHT :
                              (slp == `SLEEP_CODE_DEEP) ? SLP_DEEP :
                              (slp == `SLEEP_CODE_STANDBY) ? SLP_STANDBY : SLP_SHUTDOWN; // R14

  // Control outputs from flip-flops.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= '{1'b0, 1'b0, SYNC_PINS, SYNC_PINS, REF_1V0, SLP_SHUTDOWN};
    end else begin
      ctrl.corr_run_a <= !corr_a_reg[`CORR_BIT]; // R05
      ctrl.corr_run_b <= !corr_b_reg[`CORR_BIT]; // R06
      ctrl.sync_wide <= decode_sync(sync_wide_reg[`SYNCW_MSB:`SYNCW_LSB]); // R08
      ctrl.sync_narrow <= decode_sync({syncn, syncn, syncn, syncn[3:2]}); // R09
      ctrl.ref_sel <= ref_dec; // R10
      ctrl.sleep_sel <= slp_dec; // R14
    end
  end

  // Over-range detection shares one threshold across both channels.
  wire trip_a = over_level(chan_a_level, thr); // R02 R04
  wire trip_b = over_level(chan_b_level, thr); // R02 R04
  logic [OVR_DELAY-1:0] ovr_pipe_a_reg;
  logic [OVR_DELAY-1:0] ovr_pipe_b_reg;

  // Delay line sets the flag a fixed number of clocks after the overload.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovr_pipe_a_reg <= '0;
      ovr_pipe_b_reg <= '0;
    end else begin
      ovr_pipe_a_reg <= {ovr_pipe_a_reg[OVR_DELAY-2:0], trip_a}; // R01
      ovr_pipe_b_reg <= {ovr_pipe_b_reg[OVR_DELAY-2:0], trip_b}; // R01
    end
  end
  assign overrange_flag_a = ovr_pipe_a_reg[OVR_DELAY-1];
  assign overrange_flag_b = ovr_pipe_b_reg[OVR_DELAY-1];

  // Sleep control and wake-up timer.
  pwr_state_t pwr_state_reg;
  logic [17:0] wake_cnt_reg;
  wire [17:0] wake_load = (slp_dec == SLP_LIGHT) ? 18'(WAKE_LIGHT_CYC) :
                          (slp_dec == SLP_DEEP) ? 18'(WAKE_DEEP_CYC) :
                          (slp_dec == SLP_STANDBY) ? 18'(WAKE_STANDBY_CYC) : 18'(WAKE_SHUTDOWN_CYC); // R16

  // Low enable sleeps; high enable wakes after the mode's wake time.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_state_reg <= PWR_AWAKE;
      wake_cnt_reg <= 18'h00000;
      sleep_active <= 1'b0;
      data_ready <= 1'b1;
    end else begin
      case (pwr_state_reg)
        PWR_AWAKE: if (!en_s) begin
          pwr_state_reg <= PWR_ASLEEP; // R15
          sleep_active <= 1'b1;
          data_ready <= 1'b0;
        end
        PWR_ASLEEP: if (en_s) begin
          pwr_state_reg <= PWR_WAKING; // R15
          sleep_active <= 1'b0;
          wake_cnt_reg <= wake_load; // R16
        end
        PWR_WAKING: if (!en_s) begin
          pwr_state_reg <= PWR_ASLEEP;
          sleep_active <= 1'b1;
        end else if (wake_cnt_reg <= 18'h00001) begin
          pwr_state_reg <= PWR_AWAKE; // R16
          data_ready <= 1'b1;
        end else begin
          wake_cnt_reg <= wake_cnt_reg - 18'h00001;
        end
        default: pwr_state_reg <= PWR_AWAKE;
      endcase
    end
  end

  // Checks.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_ovr_delay;
    trip_a |-> ##12 overrange_flag_a;
  endproperty
  a_ovr_delay: assert property (p_ovr_delay) else $error("Flag A not set 12 clocks after overload."); // R01

  property p_ovr_shared;
    (chan_b_level[11:8] >= ovr_thr_reg[10:7]) |-> ##12 overrange_flag_b;
  endproperty
  a_ovr_shared: assert property (p_ovr_shared) else $error("Channel B ignored shared threshold."); // R02

  property p_thr_reset;
    $past(rst) |-> ovr_thr_reg[10:7] == 4'hF;
  endproperty
  a_thr_reset: assert property (p_thr_reset) else $error("Threshold not fifteen after reset."); // R03

  property p_corr_a;
    (wr_go && addr_reg == 7'h03) |-> ##2 (ctrl.corr_run_a == !$past(wdata[14], 2)) || $past(soft_go);
  endproperty
  a_corr_a: assert property (p_corr_a) else $error("Channel A correction control wrong."); // R05

  property p_corr_b;
    (wr_go && addr_reg == 7'h1A && !wdata[14]) |-> ##2 ctrl.corr_run_b;
  endproperty
  a_corr_b: assert property (p_corr_b) else $error("Channel B correction did not start."); // R06

  property p_sync_pins;
    (wr_go && addr_reg == 7'h0E && wdata[15:2] == 14'h2AAA) |-> ##2 ctrl.sync_wide == SYNC_PINS;
  endproperty
  a_sync_pins: assert property (p_sync_pins) else $error("Wide sync pins code misdecoded."); // R08

  property p_ref_ext;
    (wr_go && addr_reg == 7'h0F && wdata[6:4] == 3'h6) |-> ##2 ctrl.ref_sel == REF_EXT;
  endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("Unknown reference code not external."); // R10

  property p_soft_reset;
    (wr_go && addr_reg == 7'h2C && wdata == 16'hD2F0) |-> ##1 soft_key_reg == 16'hD2F0 ##1
      (soft_key_reg == 16'h0000 && ovr_thr_reg == 16'h0780 && sleep_reg == 16'h0000);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("Keyed reset failed or did not clear."); // R12

  property p_enable_high;
    (pwr_state_reg == PWR_AWAKE && en_s) |=> !sleep_active && data_ready;
  endproperty
  a_enable_high: assert property (p_enable_high) else $error("Sleeping while enable high."); // R15

  property p_wake_light;
    (pwr_state_reg == PWR_ASLEEP && en_s && slp_dec == SLP_LIGHT) ##1 en_s [*8] |-> !data_ready;
  endproperty
  a_wake_light: assert property (p_wake_light) else $error("Light sleep woke too early."); // R16

endmodule : adc_control_register_bank

// ### sim/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  // Clock.
  input wire logic sys_clk,
  // Serial control pins.
  output logic serial_clk_pin,
  output logic serial_enable_n_pin,
  output logic serial_data_in_pin,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_oe
);
  // Idle pins: clock stands still low and select is high.
  initial begin
    serial_clk_pin = 1'b0;
    serial_enable_n_pin = 1'b1;
    serial_data_in_pin = 1'b0;
  end

  // Wait a number of falling edges of the system clock.
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hold

  // One frame: read flag, 7-bit address, 16 data bits, MSB first.
  // Each serial clock phase lasts 6 system clocks so the pin synchronisers keep up.
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    logic [23:0] word;
    word = {rd, addr, wdata};
    rdata = 16'h0000;
    serial_enable_n_pin = 1'b0;
    hold(6);
    for (int i = 23; i >= 0; i--) begin
      serial_data_in_pin = word[i];
      serial_clk_pin = 1'b0;
      hold(6);
      if (i < 16) rdata[i] = serial_data_out_pin & serial_data_out_oe;
      serial_clk_pin = 1'b1;
      hold(6);
    end
    serial_clk_pin = 1'b0;
    hold(6);
    serial_enable_n_pin = 1'b1;
    // A released data line no longer shows its last bit.
    serial_data_in_pin = ~word[0];
    hold(8);
  endtask : frame
endmodule : serial_host_model

// ### sim/adc_control_register_bank_bench.sv
`timescale 1ns/100ps
`include "adc_ctrl_regs.svh"
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module adc_control_register_bank_bench;
  import adc_ctrl_pkg::*;
  logic sys_clk, rst, power_enable_pin;
  logic serial_clk_pin, serial_enable_n_pin, serial_data_in_pin, serial_data_out_pin, serial_data_out_oe;
  logic [11:0] chan_a_level, chan_b_level;
  logic [8:0] temp_value;
  logic overrange_flag_a, overrange_flag_b, sleep_active, data_ready;
  ctrl_out_t ctrl;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [6:0] addr_tab [8] = '{7'h02, 7'h03, 7'h0E, 7'h0F, 7'h1A, 7'h2C, 7'h37, 7'h10};
  logic [15:0] rst_tab [8] = '{16'h4780, 16'h4B18, 16'hAAA8, 16'hA000, 16'h4B18, 16'h0000, 16'h0000, 16'h0000};
  logic [5:0] slp_tab [4] = '{6'h00, 6'h20, 6'h30, 6'h35};
  int wake_tab [4] = '{50, 30, 2000, 200};

  adc_control_register_bank #(.OVR_DELAY(`OVR_DELAY_CYC), .WAKE_SHUTDOWN_CYC(50), .WAKE_STANDBY_CYC(30)) dut (
    .sys_clk(sys_clk), .rst(rst), .serial_clk_pin(serial_clk_pin), .serial_enable_n_pin(serial_enable_n_pin),
    .serial_data_in_pin(serial_data_in_pin), .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_oe(serial_data_out_oe), .power_enable_pin(power_enable_pin), .chan_a_level(chan_a_level),
    .chan_b_level(chan_b_level), .temp_value(temp_value), .overrange_flag_a(overrange_flag_a),
    .overrange_flag_b(overrange_flag_b), .ctrl(ctrl), .sleep_active(sleep_active), .data_ready(data_ready));

  serial_host_model host (
    .sys_clk(sys_clk), .serial_clk_pin(serial_clk_pin), .serial_enable_n_pin(serial_enable_n_pin),
    .serial_data_in_pin(serial_data_in_pin), .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_oe(serial_data_out_oe));

  // Clock of 10 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short well beyond the expected run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Register write and checked register read over the serial port.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] unused;
    host.frame(1'b0, a, d, unused);
  endtask : wr
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] got;
    host.frame(1'b1, a, 16'h0000, got);
    `CHECK(got, exp)
  endtask : rd_chk

  // Enters the chosen sleep state and checks the wake-up time.
  task automatic sleep_cycle(input int i);
    wr(`ADDR_SLEEP, {slp_tab[i], 10'h000});
    `CHECK(ctrl.sleep_sel, sleep_mode_t'(i))
    `CHECK(sleep_active, 1'b0)
    power_enable_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    `CHECK({sleep_active, data_ready}, 2'b10)
    power_enable_pin = 1'b1;
    repeat (wake_tab[i] - 5) @(negedge sys_clk);
    `CHECK(data_ready, 1'b0)
    repeat (15) @(negedge sys_clk);
    `CHECK({sleep_active, data_ready}, 2'b01)
  endtask : sleep_cycle

  // Main sequence.
  initial begin
    rst = 1'b1;
    power_enable_pin = 1'b1;
    chan_a_level = 12'h000;
    chan_b_level = 12'h000;
    temp_value = 9'h1A5;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    `CHECK(ctrl, ctrl_out_t'{1'b0, 1'b0, SYNC_PINS, SYNC_PINS, REF_1V0, SLP_SHUTDOWN})
    `CHECK({overrange_flag_a, overrange_flag_b, data_ready}, 3'b001)
    for (int i = 0; i < 8; i++) rd_chk(addr_tab[i], rst_tab[i]);
    // Temperature reads live and ignores writes.
    wr(`ADDR_TEMP, 16'hFFFF);
    rd_chk(`ADDR_TEMP, 16'h01A5);
    temp_value = 9'h0C3;
    rd_chk(`ADDR_TEMP, 16'h00C3);
    // Correction loops start per channel; clearing channel A leaves B running.
    wr(`ADDR_CORR_A, 16'h0B18);
    `CHECK({ctrl.corr_run_a, ctrl.corr_run_b}, 2'b10)
    wr(`ADDR_CORR_B, 16'h0B18);
    `CHECK({ctrl.corr_run_a, ctrl.corr_run_b}, 2'b11)
    wr(`ADDR_CORR_A, 16'h4B18);
    `CHECK({ctrl.corr_run_a, ctrl.corr_run_b}, 2'b01)
    // Every sync code in both fields.
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_SYNC_WIDE, {{7{2'(i)}}, 2'b00});
      wr(`ADDR_SYNC_REF, {{2{2'(i)}}, 12'h000});
      `CHECK(ctrl.sync_wide, sync_mode_t'(i))
      `CHECK(ctrl.sync_narrow, sync_mode_t'(i))
    end
    // Every reference code.
    for (int r = 0; r < 8; r++) begin
      wr(`ADDR_SYNC_REF, {4'hA, 5'h00, 3'(r), 4'h0});
      `CHECK(ctrl.ref_sel, (r <= 4) ? ref_sel_t'(r) : REF_EXT)
    end
    for (int i = 0; i < 4; i++) sleep_cycle(i);
    // Threshold 8 trips at half scale on either channel.
    wr(`ADDR_OVR_THR, 16'h0400);
    chan_a_level = 12'h800;
    chan_b_level = 12'h7FF;
    repeat (11) @(negedge sys_clk);
    `CHECK(overrange_flag_a, 1'b0)
    @(negedge sys_clk);
    `CHECK({overrange_flag_a, overrange_flag_b}, 2'b10)
    chan_b_level = 12'h800;
    repeat (12) @(negedge sys_clk);
    `CHECK(overrange_flag_b, 1'b1)
    // A wrong key leaves registers alone; the key restores defaults.
    wr(`ADDR_CORR_A, 16'h0B18);
    wr(`ADDR_SOFT_RESET, 16'h1234);
    rd_chk(`ADDR_OVR_THR, 16'h4400);
    wr(`ADDR_SOFT_RESET, `SOFT_RESET_KEY);
    rd_chk(`ADDR_SOFT_RESET, `SOFT_RESET_IDLE);
    rd_chk(`ADDR_OVR_THR, 16'h4780);
    rd_chk(`ADDR_CORR_A, 16'h4B18);
    `CHECK(ctrl, ctrl_out_t'{1'b0, 1'b0, SYNC_PINS, SYNC_PINS, REF_1V0, SLP_SHUTDOWN})
    repeat (14) @(negedge sys_clk);
    `CHECK({overrange_flag_a, overrange_flag_b}, 2'b00)
    tally_and_finish();
  end
endmodule : adc_control_register_bank_bench
